// File: core/lcp_fn_queue.sv
`timescale 1ns/1ns
module lcp_fn_queue #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  // filling side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // draining side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        not_full;
  } q_t;
  q_t r;
  q_t next_r;
  logic push;
  logic pop;

  // arrival order storage
  always_comb
  begin
    next_r = r;
    push   = in_valid_i && r.not_full;
    pop    = out_ready_i && (r.cnt != '0);
    if (push)
    begin
      next_r.mem[r.wr] = in_data_i;
      next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
    end
    if (pop)
      next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
    if (push && !pop)
      next_r.cnt = r.cnt + 1'b1;
    else if (pop && !push)
      next_r.cnt = r.cnt - 1'b1;
    next_r.not_full = (next_r.cnt != CW'(DEPTH));
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      r          <= '0;
      r.not_full <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign in_ready_o  = r.not_full;
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o  = r.mem[r.rd];
endmodule // lcp_fn_queue

// File: core/lcp_pkg.sv
// Operation
// [RQ1] Link address element is two octets: zero octet, then binary link address.
// [RQ2] Sent link address equals the bearer channel link identifier of that link.
// [RQ3] Function element: identifier, length, then extension bit one and function code.
// [RQ4] Function codes 0 to 7 are defined; all other seven-bit values reserved.
// [RQ5] Enter out of service at start-up and on a traffic halt request.
// [RQ6] Out of service plus traffic go request enters in service.
// [RQ7] Out of service: received message or function request raises error, no change.
// [RQ8] Halt request in service or awaiting stops timer and returns out of service.
// [RQ9] In service: received link control is acknowledged and delivered to management.
// [RQ10] In service: function request sends link control, starts timer, awaits ack.
// [RQ11] Awaiting: received link control still acknowledged and delivered, state kept.
// [RQ12] Awaiting: received acknowledge stops timer and returns to in service.
// [RQ13] Awaiting: new function request is saved, not sent nor rejected.
// [RQ14] Pending function events queue in order; next sent after re-entering service.
// [RQ15] First expiry resends and restarts timer; second expiry errors, back in service.
// [RQ16] Outgoing messages are handed to the data link as send requests.
// [RQ17] Received messages pass ordered checks first; no state change; ignored ones dropped.
// [RQ18] Message shorter than four octets raises protocol error and is dropped.
// [RQ19] Wrong protocol discriminator raises protocol error and is dropped.
// [RQ20] Bad, unknown or foreign link address raises protocol error and is dropped.
// [RQ21] Unrecognised message type raises protocol error and is dropped.
// [RQ22] Repeated mandatory element raises protocol error and is dropped.
// [RQ23] Retransmission timer expires after one second, within ten percent.
// [RQ24] Missing mandatory element raises protocol error and is dropped.
// [RQ25] Acknowledge sent at once, repeating the same set of elements.
// [RQ26] Management indications are one-cycle pulses with code and address held.
package lcp_pkg;
  // message octets
  localparam logic [7:0] ADDR_HI_OCTET       = 8'h00;
  localparam logic [7:0] MT_LINK_CONTROL     = 8'h30;
  localparam logic [7:0] MT_LINK_CONTROL_ACK = 8'h31;
  localparam logic [7:0] IE_FN_ID            = 8'h21;
  localparam logic [7:0] IE_FN_LEN           = 8'h01;
  localparam logic [7:0] PD_DEFAULT          = 8'h01;
  localparam int         FN_EXT_BIT          = 7;
  localparam int         FN_W                = 7;
  localparam int         FN_QUEUE_DEPTH      = 4;
  localparam logic [3:0] MIN_MSG_OCTETS      = 4'h4;
  // transmit octet positions
  localparam logic [2:0] OCT_PD      = 3'h0;
  localparam logic [2:0] OCT_ADDR_HI = 3'h1;
  localparam logic [2:0] OCT_ADDR_LO = 3'h2;
  localparam logic [2:0] OCT_TYPE    = 3'h3;
  localparam logic [2:0] OCT_IE_ID   = 3'h4;
  localparam logic [2:0] OCT_IE_LEN  = 3'h5;
  localparam logic [2:0] OCT_FN      = 3'h6;
  // function codes
  localparam logic [6:0] FN_IDENT_REQUEST    = 7'h00;
  localparam logic [6:0] FN_IDENT_ACK        = 7'h01;
  localparam logic [6:0] FN_IDENT_RELEASE    = 7'h02;
  localparam logic [6:0] FN_IDENT_REJECT     = 7'h03;
  localparam logic [6:0] FN_LINK_UNBLOCK     = 7'h04;
  localparam logic [6:0] FN_LINK_BLOCK       = 7'h05;
  localparam logic [6:0] FN_DEFERRED_BLOCK   = 7'h06;
  localparam logic [6:0] FN_IMMEDIATE_BLOCK  = 7'h07;
  // retransmission timer
  localparam int RETX_TIME_MS = 1000;
  localparam int RETX_TOL_PCT = 10;
  localparam int CLK_FREQ_HZ  = 125_000_000;
  localparam int RETX_CYCLES  = RETX_TIME_MS * (CLK_FREQ_HZ / 1000);
  typedef enum logic [1:0] {
    ST_OUT_OF_SERVICE = 2'b00,
    ST_IN_SERVICE     = 2'b01,
    ST_AWAIT_ACK      = 2'b10
  } lcp_state_t;
  typedef enum logic [3:0] {
    ERR_NONE          = 4'h0,
    ERR_OUT_OF_SVC    = 4'h1,
    ERR_ACK_TIMEOUT   = 4'h2,
    ERR_SHORT_MSG     = 4'h3,
    ERR_PROTO_DISC    = 4'h4,
    ERR_LINK_ADDR     = 4'h5,
    ERR_MSG_TYPE      = 4'h6,
    ERR_REPEATED_IE   = 4'h7,
    ERR_MISSING_IE    = 4'h8,
    ERR_CONTENT       = 4'h9,
    ERR_UNRECOG_IE    = 4'hA
  } err_t;
endpackage

// File: core/link_control_protocol_entity.sv
`timescale 1ns/1ns
module link_control_protocol_entity #(
  parameter int         RETX_CYCLES = lcp_pkg::RETX_CYCLES,
  parameter int         QUEUE_DEPTH = lcp_pkg::FN_QUEUE_DEPTH,
  parameter logic [7:0] PROTO_DISC  = lcp_pkg::PD_DEFAULT
) (
  // clock and reset
  input  wire logic               core_clk_i,
  input  wire logic               reset_i,
  // link configuration
  input  wire logic [7:0]         link_addr_i,
  // received octets from data link
  input  wire logic               rx_valid_i,
  input  wire logic [7:0]         rx_data_i,
  input  wire logic               rx_last_i,
  output logic                    rx_ready_o,
  // datalink_send_request octet stream
  output logic                    tx_valid_o,
  output logic [7:0]              tx_data_o,
  output logic                    tx_last_o,
  input  wire logic               tx_ready_i,
  // management requests
  input  wire logic               traffic_go_request_i,
  input  wire logic               traffic_halt_request_i,
  input  wire logic               fn_req_valid_i,
  input  wire logic [6:0]         fn_req_code_i,
  output logic                    fn_req_ready_o,
  // management indications
  output logic                    fn_ind_valid_o,
  output logic [6:0]              fn_ind_code_o,
  output logic [7:0]              fn_ind_addr_o,
  output logic                    mgmt_error_indication_o,
  output lcp_pkg::err_t           err_code_o,
  output lcp_pkg::lcp_state_t     state_o
);
  import lcp_pkg::*;
  localparam int TW = $clog2(RETX_CYCLES + 1);
  localparam logic [1:0] PH_ID = 2'h0;
  localparam logic [1:0] PH_LEN = 2'h1;
  localparam logic [1:0] PH_BODY = 2'h2;

  typedef struct packed {
    lcp_state_t    st;
    logic          retry;
    logic          tmr_run;
    logic [TW-1:0] tmr;
    logic [3:0]    rx_cnt;
    logic          pd_bad;
    logic          addr_bad;
    logic          type_bad;
    logic          is_ack;
    logic          rep;
    logic          seen;
    logic          cbad;
    logic          unrec;
    logic          ie_fn;
    logic          ie_first;
    logic [1:0]    ph;
    logic [7:0]    ie_left;
    logic [6:0]    rx_fn;
    logic          msg_pend;
    err_t          msg_err;
    logic          msg_ack;
    logic          msg_unrec;
    logic [6:0]    msg_fn;
    logic          tx_act;
    logic [2:0]    tx_idx;
    logic [7:0]    tx_type;
    logic [6:0]    tx_fn;
    logic [7:0]    tx_data;
    logic          tx_last;
    logic [6:0]    cur_fn;
    logic          rx_rdy;
    logic          fn_v;
    logic [6:0]    fn_code;
    logic [7:0]    fn_addr;
    logic          err_v;
    err_t          err_code;
  } regs_t;

  regs_t      r;
  regs_t      n;
  logic       q_valid;
  logic [6:0] q_data;
  logic       q_pop;
  logic       rx_take;
  logic       expired;

  // octet of an outgoing frame at a given position
  function automatic logic [7:0] tx_octet(input logic [2:0] idx, input logic [7:0] mtype,
                                          input logic [6:0] fn, input logic [7:0] addr);
    logic [7:0] o;
    case (idx)
      OCT_PD:      o = PROTO_DISC;
      OCT_ADDR_HI: o = ADDR_HI_OCTET; // RQ1
      OCT_ADDR_LO: o = addr; // RQ2
      OCT_TYPE:    o = mtype;
      OCT_IE_ID:   o = IE_FN_ID; // RQ3
      OCT_IE_LEN:  o = IE_FN_LEN;
      default:     o = {1'b1, fn}; // RQ3
    endcase
    return o;
  endfunction

  // pending function events, arrival order
  lcp_fn_queue #(
    .WIDTH (FN_W),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (fn_req_valid_i),
    .in_data_i   (fn_req_code_i),
    .in_ready_o  (fn_req_ready_o),
    .out_valid_o (q_valid),
    .out_data_o  (q_data),
    .out_ready_i (q_pop)
  );

  always_comb
  begin
    n       = r;
    q_pop   = 1'b0;
    rx_take = rx_valid_i && r.rx_rdy;
    expired = r.tmr_run && (r.tmr == '0);
    n.fn_v  = 1'b0;
    n.err_v = 1'b0;

    // retransmission timer countdown
    if (r.tmr_run && (r.tmr != '0))
      n.tmr = r.tmr - 1'b1; // RQ23

    // receive parser: checks only, no state change
    if (rx_take)
    begin
      if (r.rx_cnt != 4'hF)
        n.rx_cnt = r.rx_cnt + 1'b1;
      case (r.rx_cnt)
        4'h0: n.pd_bad = (rx_data_i != PROTO_DISC);        // RQ19
        4'h1: n.addr_bad = (rx_data_i != ADDR_HI_OCTET);   // RQ20
        4'h2: n.addr_bad = r.addr_bad || (rx_data_i != link_addr_i); // RQ20
        4'h3:
        begin
          n.is_ack   = (rx_data_i == MT_LINK_CONTROL_ACK);
          n.type_bad = !n.is_ack && (rx_data_i != MT_LINK_CONTROL); // RQ21
        end
        default:
        begin
          case (r.ph)
            PH_ID:
            begin
              n.ie_fn = (rx_data_i == IE_FN_ID);
              if (n.ie_fn)
              begin
                n.rep  = r.rep || r.seen;                  // RQ22
                n.seen = 1'b1;
                n.ph   = PH_LEN;
              end
              else
              begin
                n.unrec = 1'b1;
                if (!rx_data_i[7])
                  n.ph = PH_LEN;
              end
            end
            PH_LEN:
            begin
              if (r.ie_fn && (rx_data_i != IE_FN_LEN))
                n.cbad = 1'b1;
              n.ie_left  = rx_data_i;
              n.ie_first = 1'b1;
              n.ph       = (rx_data_i == 8'h00) ? PH_ID : PH_BODY;
            end
            default:
            begin
              if (r.ie_fn && r.ie_first)
              begin
                if (!rx_data_i[FN_EXT_BIT] || (rx_data_i[6:0] > FN_IMMEDIATE_BLOCK))
                  n.cbad = 1'b1;                           // RQ4
                if (!r.rep)
                  n.rx_fn = rx_data_i[6:0];
              end
              n.ie_first = 1'b0;
              n.ie_left  = r.ie_left - 1'b1;
              if (r.ie_left == 8'h01)
                n.ph = PH_ID;
            end
          endcase
        end
      endcase
      if (rx_last_i)
      begin
        // precedence of the checks
        n.msg_pend  = 1'b1; // RQ17
        n.msg_ack   = n.is_ack;
        n.msg_fn    = n.rx_fn;
        n.msg_unrec = n.unrec;
        if (n.rx_cnt < MIN_MSG_OCTETS)
          n.msg_err = ERR_SHORT_MSG; // RQ18
        else if (n.pd_bad)
          n.msg_err = ERR_PROTO_DISC; // RQ19
        else if (n.addr_bad)
          n.msg_err = ERR_LINK_ADDR; // RQ20
        else if (n.type_bad)
          n.msg_err = ERR_MSG_TYPE; // RQ21
        else if (n.rep)
          n.msg_err = ERR_REPEATED_IE; // RQ22
        else if (!n.seen)
          n.msg_err = ERR_MISSING_IE; // RQ24
        else if (n.cbad || (n.ie_fn && (n.ph != PH_ID)))
          n.msg_err = ERR_CONTENT;
        else
          n.msg_err = ERR_NONE;
        n.rx_cnt = '0;
        n.pd_bad = 1'b0;
        n.addr_bad = 1'b0;
        n.type_bad = 1'b0;
        n.rep = 1'b0;
        n.seen = 1'b0;
        n.cbad = 1'b0;
        n.unrec = 1'b0;
        n.ie_fn = 1'b0;
        n.ph = PH_ID;
      end
    end

    // transmit octet sequencer
    if (r.tx_act && tx_ready_i)
    begin
      if (r.tx_last)
        n.tx_act = 1'b0;
      else
      begin
        n.tx_idx  = r.tx_idx + 1'b1;
        n.tx_data = tx_octet(n.tx_idx, r.tx_type, r.tx_fn, link_addr_i);
        n.tx_last = (n.tx_idx == OCT_FN);
      end
    end

    // protocol state machine, one event per cycle
    if (traffic_halt_request_i)
    begin
      n.st      = ST_OUT_OF_SERVICE; // RQ5 RQ8
      n.tmr_run = 1'b0;
    end
    else if (traffic_go_request_i && (r.st == ST_OUT_OF_SERVICE))
      n.st = ST_IN_SERVICE; // RQ6
    else if (r.msg_pend && !r.tx_act)
    begin
      n.msg_pend = 1'b0;
      if (r.msg_err != ERR_NONE)
      begin
        n.err_v    = 1'b1; // RQ17
        n.err_code = r.msg_err;
      end
      else if (r.st == ST_OUT_OF_SERVICE)
      begin
        n.err_v    = 1'b1;                                 // RQ7
        n.err_code = ERR_OUT_OF_SVC;
      end
      else
      begin
        if (r.msg_unrec)
        begin
          n.err_v    = 1'b1;
          n.err_code = ERR_UNRECOG_IE;
        end
        if (!r.msg_ack)
        begin
          n.fn_v    = 1'b1; // RQ9 RQ11
          n.fn_code = r.msg_fn;
          n.fn_addr = link_addr_i;
          n.tx_act  = 1'b1; // RQ25 RQ16
          n.tx_idx  = OCT_PD;
          n.tx_type = MT_LINK_CONTROL_ACK;
          n.tx_fn   = r.msg_fn;
          n.tx_data = PROTO_DISC;
          n.tx_last = 1'b0;
        end
        else if (r.st == ST_AWAIT_ACK)
        begin
          n.tmr_run = 1'b0; // RQ12
          n.st      = ST_IN_SERVICE;
        end
      end
    end
    else if (expired && (r.st == ST_AWAIT_ACK) && !r.tx_act)
    begin
      if (!r.retry)
      begin
        n.retry   = 1'b1; // RQ15
        n.tmr     = TW'(RETX_CYCLES - 1);
        n.tx_act  = 1'b1;
        n.tx_idx  = OCT_PD;
        n.tx_type = MT_LINK_CONTROL;
        n.tx_fn   = r.cur_fn;
        n.tx_data = PROTO_DISC;
        n.tx_last = 1'b0;
      end
      else
      begin
        n.tmr_run  = 1'b0; // RQ15
        n.err_v    = 1'b1;
        n.err_code = ERR_ACK_TIMEOUT;
        n.st       = ST_IN_SERVICE;
      end
    end
    else if (q_valid && !r.tx_act && (r.st != ST_AWAIT_ACK)) // RQ13 RQ14
    begin
      q_pop = 1'b1;
      if (r.st == ST_OUT_OF_SERVICE)
      begin
        n.err_v    = 1'b1;                                 // RQ7
        n.err_code = ERR_OUT_OF_SVC;
      end
      else
      begin
        n.cur_fn  = q_data; // RQ10
        n.retry   = 1'b0;
        n.tmr_run = 1'b1;
        n.tmr     = TW'(RETX_CYCLES - 1);
        n.st      = ST_AWAIT_ACK;
        n.tx_act  = 1'b1; // RQ16
        n.tx_idx  = OCT_PD;
        n.tx_type = MT_LINK_CONTROL;
        n.tx_fn   = q_data;
        n.tx_data = PROTO_DISC;
        n.tx_last = 1'b0;
      end
    end
    n.rx_rdy = !n.msg_pend;
  end

  // state register
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      r        <= '0;
      r.st     <= ST_OUT_OF_SERVICE;                       // RQ5
      r.rx_rdy <= 1'b1;
    end
    else
      r <= n;
  end

  // outputs straight from state
  assign rx_ready_o              = r.rx_rdy;
  assign tx_valid_o              = r.tx_act;
  assign tx_data_o               = r.tx_data;
  assign tx_last_o               = r.tx_last;
  assign fn_ind_valid_o          = r.fn_v;                 // RQ26
  assign fn_ind_code_o           = r.fn_code;
  assign fn_ind_addr_o           = r.fn_addr;
  assign mgmt_error_indication_o = r.err_v;                // RQ26
  assign err_code_o              = r.err_code;
  assign state_o                 = r.st;
endmodule // link_control_protocol_entity

// File: testbench/lcp_entity_checker.sv
`timescale 1ns/1ns
module lcp_entity_checker
  import lcp_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // watched inputs
  input  wire logic [7:0] link_addr_i,
  input  wire logic       tx_ready_i,
  input  wire logic       traffic_go_request_i,
  input  wire logic       traffic_halt_request_i,
  // watched outputs
  input  wire logic       tx_valid_o,
  input  wire logic [7:0] tx_data_o,
  input  wire logic       tx_last_o,
  input  wire logic       fn_ind_valid_o,
  input  wire logic [6:0] fn_ind_code_o,
  input  wire logic [7:0] fn_ind_addr_o,
  input  wire logic       mgmt_error_indication_o,
  input  wire lcp_state_t state_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);

  a_start_out_svc: assert property (
    $fell(reset_i) |-> state_o == ST_OUT_OF_SERVICE) else $error("not out of service");
  a_halt_out_svc: assert property (
    traffic_halt_request_i |=> state_o == ST_OUT_OF_SERVICE) else $error("halt ignored");
  a_go_in_svc: assert property (
    state_o == ST_OUT_OF_SERVICE && traffic_go_request_i && !traffic_halt_request_i
    |=> state_o == ST_IN_SERVICE) else $error("go ignored");
  a_oos_holds: assert property (
    state_o == ST_OUT_OF_SERVICE && !traffic_go_request_i
    |=> state_o == ST_OUT_OF_SERVICE) else $error("left out of service");
  a_ind_addr_code: assert property (
    fn_ind_valid_o |-> fn_ind_addr_o == link_addr_i && fn_ind_code_o <= 7'h07)
    else $error("bad delivery");
  a_ind_one_cycle: assert property (
    fn_ind_valid_o |=> !fn_ind_valid_o) else $error("delivery pulse too long");
  a_err_one_cycle: assert property (
    mgmt_error_indication_o |=> !mgmt_error_indication_o) else $error("error pulse too long");
  a_tx_octet_hold: assert property (
    tx_valid_o && !tx_ready_i && !traffic_halt_request_i
    |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o)) else $error("octet dropped");
  a_tx_frame_gap: assert property (
    tx_valid_o && tx_ready_i && tx_last_o |=> !tx_valid_o) else $error("no gap after frame");
  a_fn_octet_ok: assert property (
    tx_valid_o && tx_last_o |-> tx_data_o[7] && tx_data_o[6:0] <= 7'h07)
    else $error("bad function octet");
endmodule // lcp_entity_checker

bind link_control_protocol_entity lcp_entity_checker chk (.*);

// File: testbench/peer_link_model.sv
`timescale 1ns/1ns
module peer_link_model (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  // frames from the entity
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  output logic            tx_ready_o,
  // frames to the entity
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  output logic            rx_last_o,
  input  wire logic       rx_ready_i,
  // slow acceptance
  input  wire logic       stall_i
);
  logic [47:0] shift;
  logic [55:0] frame;
  int          frames;
  // idle values at time zero
  initial
  begin
    tx_ready_o = 1'b1;
    rx_valid_o = 1'b0;
    rx_data_o  = 8'hA5;
    rx_last_o  = 1'b0;
  end
  // accept every cycle, or every other one when stalling
  always @(negedge core_clk_i)
    tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
  // collect each outgoing frame
  always @(posedge core_clk_i)
  begin
    if (reset_i)
      frames <= 0;
    else if (tx_valid_i && tx_ready_o)
    begin
      shift <= {shift[39:0], tx_data_i};
      if (tx_last_i)
      begin
        frame  <= {shift, tx_data_i};
        frames <= frames + 1;
      end
    end
  end
  // offer n octets, top first, each held until taken
  task automatic send(input logic [79:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk_i);
      rx_valid_o = 1'b1;
      rx_data_o  = f[79-8*i -: 8];
      rx_last_o  = (i == n - 1);
      do @(posedge core_clk_i); while (rx_ready_i !== 1'b1);
    end
    @(negedge core_clk_i);
    rx_valid_o = 1'b0;
    rx_data_o  = ~rx_data_o;
    rx_last_o  = 1'b0;
  endtask
endmodule // peer_link_model

// File: testbench/tb_link_control_protocol_entity.sv
`timescale 1ns/1ns
module tb_link_control_protocol_entity;
  import lcp_pkg::*;
  localparam int         RETX  = 50;
  localparam logic [7:0] LADDR = 8'h2A;
  logic       core_clk_i;
  logic       reset_i;
  logic       rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  logic [7:0] rx_data, tx_data, ind_addr_o, ind_addr;
  logic       go, halt, fn_valid, fn_ready, ind_valid, err_ind, stall;
  logic [6:0] fn_code, ind_code_o, ind_code;
  err_t       err_code, last_err;
  lcp_state_t state;
  int         error_cnt, checks_done, ind_seen, err_seen, cyc;

  link_control_protocol_entity #(.RETX_CYCLES(RETX)) dut (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .link_addr_i(LADDR),
    .rx_valid_i(rx_valid), .rx_data_i(rx_data), .rx_last_i(rx_last), .rx_ready_o(rx_ready),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_ready_i(tx_ready),
    .traffic_go_request_i(go), .traffic_halt_request_i(halt), .fn_req_valid_i(fn_valid),
    .fn_req_code_i(fn_code), .fn_req_ready_o(fn_ready), .fn_ind_valid_o(ind_valid),
    .fn_ind_code_o(ind_code_o), .fn_ind_addr_o(ind_addr_o),
    .mgmt_error_indication_o(err_ind), .err_code_o(err_code), .state_o(state));
  peer_link_model peer (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .tx_valid_i(tx_valid), .tx_data_i(tx_data),
    .tx_last_i(tx_last), .tx_ready_o(tx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .rx_last_o(rx_last), .rx_ready_i(rx_ready), .stall_i(stall));

  // clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  // catch indication pulses and cut hangs short
  always @(posedge core_clk_i)
  begin
    if (ind_valid === 1'b1)
    begin
      ind_seen++;
      ind_code = ind_code_o;
      ind_addr = ind_addr_o;
    end
    if (err_ind === 1'b1)
    begin
      err_seen++;
      last_err = err_code;
    end
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  function automatic logic [55:0] lc(input logic [6:0] c, input logic [7:0] t);
    return {PD_DEFAULT, ADDR_HI_OCTET, LADDR, t, IE_FN_ID, IE_FN_LEN, 1'b1, c};
  endfunction
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_frame(input string what, input logic [55:0] exp, input logic [55:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic fn_req(input logic [6:0] c);
    @(negedge core_clk_i);
    fn_valid = 1'b1;
    fn_code  = c;
    do @(posedge core_clk_i); while (fn_ready !== 1'b1);
    @(negedge core_clk_i);
    fn_valid = 1'b0;
  endtask
  task automatic t_out_of_service;
    int e;
    e = err_seen;
    fn_req(FN_IDENT_ACK);
    wait_cyc(5);
    peer.send({lc(FN_LINK_BLOCK, MT_LINK_CONTROL), 24'h0}, 7);
    wait_cyc(10);
    chk8("oos errors", 8'(e + 2), 8'(err_seen));
    chk8("oos code", {4'h0, ERR_OUT_OF_SVC}, {4'h0, last_err});
    chk8("oos state", 8'(ST_OUT_OF_SERVICE), {6'h0, state});
    chk8("oos frames", 8'h00, 8'(peer.frames));
    $display("test out_of_service finished");
  endtask
  task automatic t_receive;
    @(negedge core_clk_i);
    go = 1'b1;
    @(negedge core_clk_i);
    go = 1'b0;
    chk8("go state", 8'(ST_IN_SERVICE), {6'h0, state});
    for (int c = 0; c < 8; c++)
    begin
      stall = c[0];
      peer.send({lc(7'(c), MT_LINK_CONTROL), 24'h0}, 7);
      wait_cyc(30);
      chk8("delivered code", 8'(c), {1'b0, ind_code});
      chk8("delivered addr", LADDR, ind_addr);
      chk_frame("ack frame", lc(7'(c), MT_LINK_CONTROL_ACK), peer.frame);
    end
    $display("test receive finished");
  endtask
  task automatic t_send_ack;
    int fr;
    stall = 1'b0;
    fr = peer.frames;
    fn_req(FN_LINK_UNBLOCK);
    wait_cyc(12);
    chk_frame("sent frame", lc(FN_LINK_UNBLOCK, MT_LINK_CONTROL), peer.frame);
    chk8("await state", 8'(ST_AWAIT_ACK), {6'h0, state});
    peer.send({lc(FN_IDENT_REJECT, MT_LINK_CONTROL), 24'h0}, 7);
    fn_req(FN_DEFERRED_BLOCK);
    wait_cyc(12);
    chk8("ack while waiting", 8'(fr + 2), 8'(peer.frames));
    chk8("still waiting", 8'(ST_AWAIT_ACK), {6'h0, state});
    peer.send({lc(FN_LINK_UNBLOCK, MT_LINK_CONTROL_ACK), 24'h0}, 7);
    wait_cyc(20);
    chk_frame("queued frame", lc(FN_DEFERRED_BLOCK, MT_LINK_CONTROL), peer.frame);
    chk8("frames after ack", 8'(fr + 3), 8'(peer.frames));
    peer.send({lc(FN_DEFERRED_BLOCK, MT_LINK_CONTROL_ACK), 24'h0}, 7);
    wait_cyc(5);
    chk8("back in service", 8'(ST_IN_SERVICE), {6'h0, state});
    $display("test send_ack finished");
  endtask
  task automatic t_timer;
    int fr, e;
    fr = peer.frames;
    e = err_seen;
    fn_req(FN_IDENT_RELEASE);
    wait_cyc(44);
    chk8("no early resend", 8'(fr + 1), 8'(peer.frames));
    wait_cyc(20);
    chk8("one resend", 8'(fr + 2), 8'(peer.frames));
    wait_cyc(70);
    chk8("timeout errors", 8'(e + 1), 8'(err_seen));
    chk8("timeout code", {4'h0, ERR_ACK_TIMEOUT}, {4'h0, last_err});
    chk8("timeout state", 8'(ST_IN_SERVICE), {6'h0, state});
    chk8("no third send", 8'(fr + 2), 8'(peer.frames));
    $display("test timer finished");
  endtask
  task automatic t_errors;
    logic [79:0] f [8] = '{80'h01002A00000000000000, 80'h02002A30210185000000,
      80'h01012A30210185000000, 80'h01002B30210185000000, 80'h01002A32210185000000,
      80'h01002A30210185210185, 80'h01002A30000000000000, 80'h01002A30210188000000};
    int          n [8] = '{3, 7, 7, 7, 7, 10, 4, 7};
    err_t        c [8] = '{ERR_SHORT_MSG, ERR_PROTO_DISC, ERR_LINK_ADDR, ERR_LINK_ADDR,
      ERR_MSG_TYPE, ERR_REPEATED_IE, ERR_MISSING_IE, ERR_CONTENT};
    int          e, i0, fr;
    for (int k = 0; k < 8; k++)
    begin
      e  = err_seen;
      i0 = ind_seen;
      fr = peer.frames;
      peer.send(f[k], n[k]);
      wait_cyc(25);
      chk8("bad msg error", 8'(e + 1), 8'(err_seen));
      chk8("bad msg code", {4'h0, c[k]}, {4'h0, last_err});
      chk8("bad msg dropped", 8'(i0 + fr), 8'(ind_seen + peer.frames));
      chk8("bad msg state", 8'(ST_IN_SERVICE), {6'h0, state});
    end
    $display("test errors finished");
  endtask
  task automatic t_halt;
    int fr, e;
    fn_req(FN_IMMEDIATE_BLOCK);
    wait_cyc(20);
    chk8("halt from await", 8'(ST_AWAIT_ACK), {6'h0, state});
    @(negedge core_clk_i);
    halt = 1'b1;
    @(negedge core_clk_i);
    halt = 1'b0;
    chk8("halted state", 8'(ST_OUT_OF_SERVICE), {6'h0, state});
    fr = peer.frames;
    e = err_seen;
    wait_cyc(120);
    chk8("timer stopped", 8'(fr + e), 8'(peer.frames + err_seen));
    $display("test halt finished");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    {error_cnt, checks_done, ind_seen, err_seen, cyc} = '0;
    {go, halt, fn_valid, stall, fn_code} = '0;
    reset_i = 1'b1;
    wait_cyc(8);
    @(negedge core_clk_i);
    reset_i = 1'b0;
    chk8("reset state", 8'(ST_OUT_OF_SERVICE), {6'h0, state});
    chk8("reset ready", 8'h03, {6'h0, fn_ready, rx_ready});
    t_out_of_service();
    t_receive();
    t_send_ack();
    t_timer();
    t_errors();
    t_halt();
    complete_run();
  end
endmodule // tb_link_control_protocol_entity
